// ---- core/pxfmt_pkg.sv ----
// Constants shared by the pixel output formatter and its helpers.
// Assumes a 32-bit APB slave with one register per aligned word.
package pxfmt_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_FORMAT   = 8'h18;
  localparam logic [7:0] IDX_HS_WIDTH = 8'h19;
  localparam logic [7:0] IDX_DISABLE  = 8'h1a;
  localparam logic [7:0] IDX_POWER    = 8'h1b;
  localparam logic [7:0] IDX_PLL_TUNE = 8'h1c;
  localparam logic [7:0] IDX_STATUS   = 8'h20;
  localparam int         ADDR_SHIFT   = 2;

  // Reset values, and the mask of writable power bits
  localparam logic [7:0] RST_FORMAT   = 8'h00;
  localparam logic [7:0] RST_HS_WIDTH = 8'h10;
  localparam logic [7:0] RST_DISABLE  = 8'h00;
  localparam logic [7:0] RST_POWER    = 8'h00;
  localparam logic [7:0] RST_PLL_TUNE = 8'h49;
  localparam logic [7:0] POWER_MASK   = 8'h0f;

  // Field positions of output_format_control
  localparam int FMT_WIDE     = 0;
  localparam int FMT_ILEAVE   = 1;
  localparam int FMT_SWAP     = 2;
  localparam int FMT_CHROMA_ORDER_SELECT = 3;
  localparam int FMT_422      = 4;
  localparam int FMT_CLK_POL  = 5;
  localparam int FMT_FS_POL   = 6;
  localparam int FMT_LS_POL   = 7;

  // Field positions of output_pin_disable and power_down_control
  localparam int DIS_CLK_LO   = 6;
  localparam int DIS_CLK_HI   = 7;
  localparam int PWR_PLL      = 3;

  // Field positions of the status register
  localparam int ST_LEVEL_LO  = 0;
  localparam int ST_LINE_SYNC = 2;
  localparam int ST_PHASE     = 3;
  localparam int ST_STARVED   = 4;

  // Pixel word layout in the buffer
  localparam int PIX_W        = 26;
  localparam int PIX_FS       = 25;
  localparam int PIX_LS       = 24;
endpackage

// ---- core/pxfmt_sync.sv ----
// Three-stage synchroniser for a level from another clock domain.
// Assumes the level is slow against clk_i; the output follows once stages two
// and three agree, which rejects a single metastable sample.
`timescale 1ns/1ps
module pxfmt_sync (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic en_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_ff;   // First stage, read only by the second
  logic s2_ff;   // Second stage
  logic s3_ff;   // Third stage
  logic q_ff;    // Agreed level

  // Shift chain and agreement check
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      q_ff  <= 1'b0;
    end else if (en_i) begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        q_ff <= s3_ff;
      end
    end
  end

  assign q_o = q_ff;
endmodule

// ---- core/pxfmt_buf.sv ----
// Two-entry valid/ready buffer in the pixel data path.
// Assumes both sides run on clk_i; ready and valid come straight from flops.
`timescale 1ns/1ps
module pxfmt_buf #(
  parameter int WIDTH = 26
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             en_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  output logic [1:0]            level_o
);
  logic [WIDTH-1:0] mem_ff [2];   // Storage entries
  logic             rd_ff;        // Read index
  logic             wr_ff;        // Write index
  logic [1:0]       cnt_ff;       // Occupancy
  logic [1:0]       nxt_cnt;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;

  assign nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};

  // Pointers and occupancy; full and empty are derived from the count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ff  <= 1'b0;
      wr_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (en_i) begin
      if (push) begin
        mem_ff[wr_ff] <= in_data_i;
        wr_ff         <= ~wr_ff;
      end
      if (pop) begin
        rd_ff <= ~rd_ff;
      end
      cnt_ff <= nxt_cnt;
    end
  end

  assign in_ready_o  = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o  = mem_ff[rd_ff];
  assign level_o     = cnt_ff;
endmodule

// ---- core/pxfmt_top.sv ----
// Output formatting stage of a triple-channel digitiser: APB registers,
// pixel buffer, bus width/interleave/swap, 4:2:2 decimation, sync outputs.
// Assumes pixels arrive on clk_i with valid/ready, and the pixel clock
// arrives from another domain, far slower than clk_i, and is sampled here.
`timescale 1ns/1ps
module pxfmt_top
  import pxfmt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        en_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [9:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Pixel stream in
  input  wire logic        pix_valid_i,
  output logic             pix_ready_o,
  input  wire logic [7:0]  pix_red_i,
  input  wire logic [7:0]  pix_green_i,
  input  wire logic [7:0]  pix_blue_i,
  input  wire logic        pix_line_start_i,
  input  wire logic        pix_frame_sync_i,
  // Recovered pixel clock from the other domain
  input  wire logic        pixel_clk_i,
  // Output pins
  output logic             pixel_out_clock_o,
  output logic             pixel_out_clock_oe_o,
  output logic             line_sync_out_o,
  output logic             frame_sync_out_o,
  output logic [7:0]       red_primary_bus_o,
  output logic             red_primary_bus_oe_o,
  output logic [7:0]       red_secondary_bus_o,
  output logic             red_secondary_bus_oe_o,
  output logic [7:0]       green_primary_bus_o,
  output logic             green_primary_bus_oe_o,
  output logic [7:0]       green_secondary_bus_o,
  output logic             green_secondary_bus_oe_o,
  output logic [7:0]       blue_primary_bus_o,
  output logic             blue_primary_bus_oe_o,
  output logic [7:0]       blue_secondary_bus_o,
  output logic             blue_secondary_bus_oe_o,
  // Power controls
  output logic [2:0]       chan_power_down_o,
  output logic             pll_power_down_o,
  output logic [7:0]       pll_tuning_o
);
  // Registers
  logic [7:0]  fmt_ff;        // output_format_control
  logic [7:0]  hsw_ff;        // line_sync_pulse_width
  logic [7:0]  dis_ff;        // output_pin_disable
  logic [7:0]  pwr_ff;        // power_down_control
  logic [7:0]  tune_ff;       // pll_tuning_value
  logic        pready_ff;     // APB answer
  logic [31:0] prdata_ff;     // APB read data
  logic        pslverr_ff;    // APB error

  // Datapath state
  logic        clk_prev_ff;   // Last synced pixel clock level
  logic        dclk_ff;       // Output pixel clock
  logic        dclk_oe_ff;    // Output pixel clock enable
  logic [5:0]  oe_ff;         // Byte enables Rp Rs Gp Gs Bp Bs
  logic [7:0]  lcnt_ff;       // Line sync pixels still to go
  logic        phase_ff;      // 48-bit: 0 first pixel of pair
  logic        odd_ff;        // 4:2:2: pixel parity in line
  logic [7:0]  v_hold_ff;     // 4:2:2: V of last even pixel
  logic [23:0] stash_ff;      // 48-bit: first pixel awaiting its pair
  logic [23:0] prim_ff;       // Primary bus bytes R G B
  logic [23:0] sec_ff;        // Secondary bus bytes R G B
  logic        ls_ff;         // Line sync pin
  logic        fs_ff;         // Frame sync pin
  logic        starved_ff;    // Tick came with no pixel buffered

  // APB decode
  wire         apb_acc  = psel_i & penable_i & ~pready_ff;
  wire         apb_wr   = apb_acc & pwrite_i;
  wire [7:0]   idx      = paddr_i[9:ADDR_SHIFT];
  wire         aligned  = (paddr_i[ADDR_SHIFT-1:0] == 2'h0);
  wire         hit_fmt  = aligned & (idx == IDX_FORMAT);
  wire         hit_hsw  = aligned & (idx == IDX_HS_WIDTH);
  wire         hit_dis  = aligned & (idx == IDX_DISABLE);
  wire         hit_pwr  = aligned & (idx == IDX_POWER);
  wire         hit_tune = aligned & (idx == IDX_PLL_TUNE);
  wire         hit_st   = aligned & (idx == IDX_STATUS);
  wire         hit_any  = hit_fmt | hit_hsw | hit_dis | hit_pwr | hit_tune | hit_st;
  wire [7:0]   status;
  wire [7:0]   rd_mux   = hit_fmt  ? fmt_ff  :
                          hit_hsw  ? hsw_ff  :
                          hit_dis  ? dis_ff  :
                          hit_pwr  ? pwr_ff  :
                          hit_tune ? tune_ff :
                          hit_st   ? status  : 8'h00;

  // Format fields
  wire         wide     = fmt_ff[FMT_WIDE];
  wire         ileave   = fmt_ff[FMT_ILEAVE];
  wire         swap     = fmt_ff[FMT_SWAP];
  wire         chroma_order_select = fmt_ff[FMT_CHROMA_ORDER_SELECT];
  wire         mode422  = fmt_ff[FMT_422];
  wire         clk_pol  = fmt_ff[FMT_CLK_POL];

  // Pixel clock sampling and edge finding
  wire         clk_lvl;
  wire         clk_rise = clk_lvl & ~clk_prev_ff;
  wire         clk_fall = ~clk_lvl & clk_prev_ff;
  wire         tick     = clk_pol ? clk_rise : clk_fall;

  // Buffer
  wire [PIX_W-1:0] in_word = {pix_frame_sync_i, pix_line_start_i,
                              pix_red_i, pix_green_i, pix_blue_i};
  wire [PIX_W-1:0] word;
  wire             word_valid;
  wire [1:0]       level;
  wire             take     = tick & word_valid;

  // Fields of the word taken
  wire         w_ls     = word[PIX_LS];
  wire         w_fs     = word[PIX_FS];
  wire [7:0]   w_r      = word[23:16];
  wire [7:0]   w_g      = word[15:8];
  wire [7:0]   w_b      = word[7:0];

  // 4:2:2: red lane carries U on even pixels and V on odd ones
  wire         even_px  = w_ls | ~odd_ff;
  wire [7:0]   v_sel    = chroma_order_select ? w_r : v_hold_ff;
  wire [7:0]   chroma   = even_px ? w_b : v_sel;
  wire [23:0]  fmt_px   = mode422 ? {chroma, w_g, 8'h00}
                                  : {w_r, w_g, w_b};

  // 48-bit slot: phase restarts after line sync, swap reverses buses
  wire         ls_last  = (lcnt_ff == 8'h01) & ~w_ls;
  wire         cur_ph   = (w_ls | ls_last) ? 1'b0 : phase_ff;
  wire         to_sec   = cur_ph ^ swap;

  // Next values for the output buses
  logic [23:0] nxt_prim;
  logic [23:0] nxt_sec;
  logic [23:0] nxt_stash;
  always_comb begin
    nxt_prim  = prim_ff;
    nxt_sec   = sec_ff;
    nxt_stash = stash_ff;
    if (!wide) begin
      nxt_prim = fmt_px;
      nxt_sec  = 24'h000000;
    end else if (ileave) begin
      // Each bus loads on its own tick, so they change on opposite edges
      if (to_sec) begin
        nxt_sec = fmt_px;
      end else begin
        nxt_prim = fmt_px;
      end
    end else if (!cur_ph) begin
      // Hold the first pixel until its partner arrives
      nxt_stash = fmt_px;
    end else begin
      // Both buses load together on the second pixel
      nxt_prim = swap ? fmt_px : stash_ff;
      nxt_sec  = swap ? stash_ff : fmt_px;
    end
  end

  // Output clock: mirrors the input at 24 bits, halves it at 48 bits
  wire         nxt_dclk = wide ? (tick ? ~dclk_ff : dclk_ff) : clk_lvl;

  assign status = {3'h0, starved_ff, phase_ff, ls_ff ^ fmt_ff[FMT_LS_POL], level};

  // Synchroniser for the pixel clock
  pxfmt_sync u_clk_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .en_i   (en_i),
    .d_i    (pixel_clk_i),
    .q_o    (clk_lvl)
  );

  // Two-entry buffer; a late tick simply leaves the word waiting
  pxfmt_buf #(
    .WIDTH (PIX_W)
  ) u_buf (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .en_i        (en_i),
    .in_valid_i  (pix_valid_i),
    .in_ready_o  (pix_ready_o),
    .in_data_i   (in_word),
    .out_valid_o (word_valid),
    .out_ready_i (tick),
    .out_data_o  (word),
    .level_o     (level)
  );

  // APB slave: one wait state, answer and data from flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (en_i) begin
      pready_ff  <= apb_acc;
      pslverr_ff <= apb_acc & ~hit_any;
      if (apb_acc) begin
        prdata_ff <= {24'h000000, rd_mux};
      end
    end
  end

  // Register writes; status is read only, reserved power bits stay zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fmt_ff  <= RST_FORMAT;
      hsw_ff  <= RST_HS_WIDTH;
      dis_ff  <= RST_DISABLE;
      pwr_ff  <= RST_POWER;
      tune_ff <= RST_PLL_TUNE;
    end else if (en_i && apb_wr) begin
      if (hit_fmt)  fmt_ff  <= pwdata_i[7:0];
      if (hit_hsw)  hsw_ff  <= pwdata_i[7:0];
      if (hit_dis)  dis_ff  <= pwdata_i[7:0];
      if (hit_pwr)  pwr_ff  <= pwdata_i[7:0] & POWER_MASK;
      if (hit_tune) tune_ff <= pwdata_i[7:0];
    end
  end

  // Pin enables; a set disable bit wins over any format setting
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_ff      <= 6'h00;
      dclk_oe_ff <= 1'b0;
    end else if (en_i) begin
      oe_ff      <= ~dis_ff[5:0];
      dclk_oe_ff <= ~(dis_ff[DIS_CLK_LO] | dis_ff[DIS_CLK_HI]);
    end
  end

  // Clock mirror and line sync counter
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_prev_ff <= 1'b0;
      dclk_ff     <= 1'b0;
      lcnt_ff     <= 8'h00;
    end else if (en_i) begin
      clk_prev_ff <= clk_lvl;
      dclk_ff     <= nxt_dclk;
      if (take && w_ls) begin
        lcnt_ff <= hsw_ff;
      end else if (take && lcnt_ff != 8'h00) begin
        lcnt_ff <= lcnt_ff - 8'h01;
      end
    end
  end

  // Pixel datapath, updated only on the active pixel clock edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_ff   <= 1'b0;
      odd_ff     <= 1'b0;
      v_hold_ff  <= 8'h00;
      stash_ff   <= 24'h000000;
      prim_ff    <= 24'h000000;
      sec_ff     <= 24'h000000;
      ls_ff      <= 1'b0;
      fs_ff      <= 1'b0;
      starved_ff <= 1'b0;
    end else if (en_i && tick) begin
      starved_ff <= ~word_valid;
      if (word_valid) begin
        // Phase restarts once line sync ends
        phase_ff  <= ~cur_ph;
        odd_ff    <= even_px;
        if (even_px) begin
          v_hold_ff <= w_r;
        end
        stash_ff  <= nxt_stash;
        prim_ff   <= nxt_prim;
        sec_ff    <= nxt_sec;
        ls_ff     <= w_ls | (lcnt_ff > 8'h01);
        fs_ff     <= w_fs;
      end
    end
  end

  // Pins; polarity applied at the output
  assign pixel_out_clock_o        = dclk_ff;
  assign pixel_out_clock_oe_o     = dclk_oe_ff;
  assign line_sync_out_o          = ls_ff ^ fmt_ff[FMT_LS_POL];
  assign frame_sync_out_o         = fs_ff ^ fmt_ff[FMT_FS_POL];
  assign red_primary_bus_o        = prim_ff[23:16];
  assign green_primary_bus_o      = prim_ff[15:8];
  assign blue_primary_bus_o       = prim_ff[7:0];
  assign red_secondary_bus_o      = sec_ff[23:16];
  assign green_secondary_bus_o    = sec_ff[15:8];
  assign blue_secondary_bus_o     = sec_ff[7:0];
  assign red_primary_bus_oe_o     = oe_ff[0];
  assign red_secondary_bus_oe_o   = oe_ff[1];
  assign green_primary_bus_oe_o   = oe_ff[2];
  assign green_secondary_bus_oe_o = oe_ff[3];
  assign blue_primary_bus_oe_o    = oe_ff[4];
  assign blue_secondary_bus_oe_o  = oe_ff[5];
  assign chan_power_down_o        = pwr_ff[2:0];
  assign pll_power_down_o         = pwr_ff[PWR_PLL];
  assign pll_tuning_o             = tune_ff;
  assign pready_o                 = pready_ff;
  assign prdata_o                 = prdata_ff;
  assign pslverr_o                = pslverr_ff;
endmodule

// ---- verif/pxfmt_checker.sv ----
// Concurrent checks on the pixel output formatter, bound to its top module.
// Assumes the bench writes mapped offsets only, so shadow registers stay true.
`timescale 1ns/1ps
module pxfmt_checker
  import pxfmt_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [9:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pix_valid_i,
  input wire logic        pix_ready_o,
  input wire logic        pixel_out_clock_o,
  input wire logic        pixel_out_clock_oe_o,
  input wire logic        line_sync_out_o,
  input wire logic        frame_sync_out_o,
  input wire logic [7:0]  red_primary_bus_o,
  input wire logic [7:0]  red_secondary_bus_o,
  input wire logic [7:0]  green_secondary_bus_o,
  input wire logic [7:0]  blue_secondary_bus_o,
  input wire logic [5:0]  oe_vec,
  input wire logic [2:0]  chan_power_down_o,
  input wire logic        pll_power_down_o
);
  logic       wr_ok;   // Completed write
  logic       wr_fmt;  // Completed format write
  logic       wr_dis;  // Completed disable write
  logic       wr_pwr;  // Completed power write
  logic [7:0] fmt_ff;  // Shadow of the format register
  logic [7:0] dis_ff;  // Shadow of the disable register
  logic [7:0] pwr_ff;  // Shadow of the power register
  logic       wide_ff; // 48-bit mode seen since reset
  logic       busy_ff; // A pixel was accepted since reset
  logic [5:0] age_ff;  // Cycles since the last format write, saturating
  assign wr_ok  = psel_i & penable_i & pwrite_i & pready_o;
  assign wr_fmt = wr_ok & (paddr_i == {IDX_FORMAT, 2'b00});
  assign wr_dis = wr_ok & (paddr_i == {IDX_DISABLE, 2'b00});
  assign wr_pwr = wr_ok & (paddr_i == {IDX_POWER, 2'b00});
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Shadows load at the edge that completes the write
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fmt_ff  <= 8'h00;
      dis_ff  <= 8'h00;
      pwr_ff  <= 8'h00;
      wide_ff <= 1'b0;
      busy_ff <= 1'b0;
      age_ff  <= 6'h00;
    end else begin
      if (wr_fmt) fmt_ff <= pwdata_i[7:0];
      if (wr_dis) dis_ff <= pwdata_i[7:0];
      if (wr_pwr) pwr_ff <= pwdata_i[7:0] & POWER_MASK;
      wide_ff <= wide_ff | fmt_ff[FMT_WIDE];
      busy_ff <= busy_ff | (pix_valid_i & pix_ready_o);
      age_ff  <= wr_fmt ? 6'h00 : age_ff + {5'h00, age_ff != 6'h3f};
    end
  end
  property p_sec_low;
    !wide_ff && !fmt_ff[FMT_WIDE] |-> {red_secondary_bus_o, green_secondary_bus_o,
      blue_secondary_bus_o} == 24'h000000;
  endproperty
  a_sec_low: assert property (p_sec_low) else $error("secondary bus not low");
  property p_ileave;
    fmt_ff[FMT_WIDE] && fmt_ff[FMT_ILEAVE] && $stable(fmt_ff) && $changed(red_primary_bus_o)
      |-> $stable(red_secondary_bus_o);
  endproperty
  a_ileave: assert property (p_ileave) else $error("buses moved together");
  // Narrow mode only: the output clock then mirrors the synced pixel clock level
  property p_edge;
    !wide_ff && !fmt_ff[FMT_WIDE] && $stable(fmt_ff) && $changed(red_primary_bus_o)
      |-> $changed(pixel_out_clock_o) && (pixel_out_clock_o == fmt_ff[FMT_CLK_POL]);
  endproperty
  a_edge: assert property (p_edge) else $error("data changed on wrong edge");
  property p_sync_pol;
    !busy_ff && (age_ff == 6'd40) |-> (line_sync_out_o == fmt_ff[FMT_LS_POL]) &&
      (frame_sync_out_o == fmt_ff[FMT_FS_POL]);
  endproperty
  a_sync_pol: assert property (p_sync_pol) else $error("idle sync level wrong");
  property p_oe;
    $past(nrst_i) && (dis_ff == $past(dis_ff)) |-> oe_vec == ~dis_ff[5:0];
  endproperty
  a_oe: assert property (p_oe) else $error("byte enable wrong");
  property p_clk_oe;
    wr_dis |=> ##1 pixel_out_clock_oe_o == !($past(pwdata_i[7], 2) | $past(pwdata_i[6], 2));
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock enable wrong");
  property p_chan;
    !wr_pwr |-> chan_power_down_o == pwr_ff[2:0];
  endproperty
  a_chan: assert property (p_chan) else $error("channel power-down wrong");
  property p_pll;
    wr_pwr |=> pll_power_down_o == $past(pwdata_i[PWR_PLL]);
  endproperty
  a_pll: assert property (p_pll) else $error("PLL power-down wrong");
endmodule

bind pxfmt_top pxfmt_checker u_chk (.*,
  .oe_vec({blue_secondary_bus_oe_o, blue_primary_bus_oe_o, green_secondary_bus_oe_o,
    green_primary_bus_oe_o, red_secondary_bus_oe_o, red_primary_bus_oe_o}));

// ---- verif/pxfmt_sink.sv ----
// Downstream sink model: resolves three-stated pins, logs each new bus word.
// Assumes pull-downs on the pins and a sampling clock far faster than pixels.
`timescale 1ns/1ps
module pxfmt_sink (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       clr_i,
  input wire logic       ck_i,
  input wire logic       ck_oe_i,
  input wire logic [7:0] rp_i,
  input wire logic       rp_oe_i,
  input wire logic [7:0] rs_i,
  input wire logic       rs_oe_i,
  input wire logic [7:0] bp_i,
  input wire logic       bp_oe_i,
  input wire logic       ls_i
);
  logic        ck_pin;     // Clock pin level, pulled low when released
  logic [23:0] key;        // Resolved red primary, red secondary, blue primary
  logic        ck_q;       // Clock level one cycle ago
  logic [23:0] last_q;     // Last word logged
  logic [23:0] log_q [16]; // Word log, read by the bench
  int          n_q;        // Words logged since clear
  int          ls_cyc_q;   // Cycles with line sync high since clear
  assign ck_pin = ck_oe_i & ck_i;
  assign key = {rp_oe_i ? rp_i : 8'h00, rs_oe_i ? rs_i : 8'h00, bp_oe_i ? bp_i : 8'h00};
  // Look at either clock edge; repeated words are not logged
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ck_q <= 1'b0;
      last_q <= 24'h000000;
      n_q <= 0;
      ls_cyc_q <= 0;
    end else begin
      ck_q <= ck_pin;
      if (clr_i) begin
        n_q <= 0;
        ls_cyc_q <= 0;
      end else begin
        if (ls_i) ls_cyc_q <= ls_cyc_q + 1;
        if (ck_q != ck_pin && key != last_q) begin
          log_q[n_q % 16] <= key;
          n_q <= n_q + 1;
          last_q <= key;
        end
      end
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// Bench: APB register tests, then pixel streams watched by the sink model.
// Assumes a pixel clock of 200 ns.
`timescale 1ns/1ps
module tb_top;
  import pxfmt_pkg::*;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pclk = 1'b0;
  logic [9:0]  paddr_i = 10'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic        pv = 1'b0, pls = 1'b0, pfs = 1'b0, clr = 1'b0, e;
  logic [7:0]  pr = 8'h00, pg = 8'h00, pb = 8'h00, rp, rs, gp, gs, bp, bs, tune;
  logic        pready_o, pslverr_o, prdy, ock, ock_oe, ls_o, fs_o, pll_pd;
  logic [5:0]  oe;
  logic [2:0]  chan_pd;
  logic [7:0]  idx [5] = '{IDX_FORMAT, IDX_HS_WIDTH, IDX_DISABLE, IDX_POWER, IDX_PLL_TUNE};
  logic [7:0]  rst [5] = '{RST_FORMAT, RST_HS_WIDTH, RST_DISABLE, RST_POWER, RST_PLL_TUNE};
  int          num_errors = 0;
  int          n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  always #100 pclk = ~pclk;
  pxfmt_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .pix_valid_i(pv),
    .pix_ready_o(prdy), .pix_red_i(pr), .pix_green_i(pg), .pix_blue_i(pb),
    .pix_line_start_i(pls), .pix_frame_sync_i(pfs), .pixel_clk_i(pclk),
    .pixel_out_clock_o(ock), .pixel_out_clock_oe_o(ock_oe), .line_sync_out_o(ls_o),
    .frame_sync_out_o(fs_o), .red_primary_bus_o(rp), .red_primary_bus_oe_o(oe[0]),
    .red_secondary_bus_o(rs), .red_secondary_bus_oe_o(oe[1]), .green_primary_bus_o(gp),
    .green_primary_bus_oe_o(oe[2]), .green_secondary_bus_o(gs),
    .green_secondary_bus_oe_o(oe[3]), .blue_primary_bus_o(bp), .blue_primary_bus_oe_o(oe[4]),
    .blue_secondary_bus_o(bs), .blue_secondary_bus_oe_o(oe[5]),
    .chan_power_down_o(chan_pd), .pll_power_down_o(pll_pd), .pll_tuning_o(tune));
  pxfmt_sink sink (.clk_i(clk_i), .nrst_i(nrst_i), .clr_i(clr), .ck_i(ock),
    .ck_oe_i(ock_oe), .rp_i(rp), .rp_oe_i(oe[0]), .rs_i(rs), .rs_oe_i(oe[1]), .bp_i(bp),
    .bp_oe_i(oe[4]), .ls_i(ls_o));
  // Counts a comparison, reports a mismatch
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {i, 2'b00};
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(negedge clk_i);
    while (pready_o !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk_i);
    end
    if (n == 50) num_errors++;
    r = prdata_o;
    e = pslverr_o;
    @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] exp);
    apb(1'b0, i, 32'h0);
    check("register read", r, exp);
  endtask
  // Pushes n pixels from a line start
  task automatic stream(input int n);
    for (int k = 0; k < n; k++) begin
      pv <= 1'b1;
      clr <= (k == 0);
      pls <= (k == 0);
      pfs <= (k == 0);
      pr <= 8'h10 + k[7:0];
      pg <= 8'h30 + k[7:0];
      pb <= 8'h20 + k[7:0];
      @(negedge clk_i);
      while (prdy !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
    end
    pv <= 1'b0;
    @(posedge clk_i);
  endtask
  // Waits, under a bound, for the sink to log cnt words
  task automatic waitlog(input int cnt);
    int n;
    n = 0;
    while (sink.n_q < cnt && n < 400) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 400) num_errors++;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    foreach (idx[i]) rd(idx[i], {24'h0, rst[i]});
    apb(1'b0, 8'h1d, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    wr_power: begin
      apb(1'b1, IDX_POWER, 32'hff);
      rd(IDX_POWER, 32'h0f);
      check("channel power-down", {29'h0, chan_pd}, 32'h7);
      check("PLL power-down", {31'h0, pll_pd}, 32'h1);
      apb(1'b1, IDX_POWER, 32'h0);
      check("PLL power-up", {31'h0, pll_pd}, 32'h0);
      apb(1'b1, IDX_PLL_TUNE, 32'h4c);
      check("PLL tuning", {24'h0, tune}, 32'h4c);
    end
    $display("register test done");
    apb(1'b1, IDX_FORMAT, 32'hc0);
    repeat (48) @(posedge clk_i);
    check("line sync idle", {31'h0, ls_o}, 32'h1);
    check("frame sync idle", {31'h0, fs_o}, 32'h1);
    apb(1'b1, IDX_FORMAT, 32'h00);
    apb(1'b1, IDX_DISABLE, 32'h15);
    @(posedge clk_i);
    check("byte enables", {26'h0, oe}, 32'h2a);
    apb(1'b1, IDX_DISABLE, 32'h80);
    @(posedge clk_i);
    check("clock enable", {31'h0, ock_oe}, 32'h0);
    apb(1'b1, IDX_DISABLE, 32'h00);
    $display("polarity and disable test done");
    apb(1'b1, IDX_HS_WIDTH, 32'h03);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, IDX_FORMAT, p * 32'h20);
      stream(4);
      waitlog(4);
      for (int i = 0; i < 4; i++)
        check("narrow word", sink.log_q[i], 32'h100020 + i * 32'h010001);
      check("line sync width", sink.ls_cyc_q, 32'd24);
    end
    for (int o = 0; o < 2; o++) begin
      apb(1'b1, IDX_FORMAT, 32'h10 + o * 32'h08);
      stream(4);
      waitlog(4);
      for (int i = 0; i < 4; i++)
        check("chroma word", sink.log_q[i], (i % 2) ? (32'h0f + i + o) << 16 :
          (32'h20 + i) << 16);
    end
    $display("narrow mode test done");
    apb(1'b1, IDX_HS_WIDTH, 32'h02);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, IDX_FORMAT, 32'h01 + s * 32'h04);
      stream(4);
      waitlog(2);
      for (int i = 0; i < 2; i++)
        check("wide word", sink.log_q[i], (s ? 32'h111021 : 32'h101120) +
          i * 32'h020202);
      check("wide line sync", sink.ls_cyc_q, 32'd16);
    end
    apb(1'b1, IDX_FORMAT, 32'h03);
    stream(4);
    waitlog(4);
    for (int i = 1; i < 4; i += 2)
      check("interleaved word", sink.log_q[i], 32'h101120 + i / 2 * 32'h020202);
    $display("wide mode test done");
    stop_test();
  end
endmodule
